// >>> inc/dcm_pkg.sv
package dcm_pkg;

  localparam int NCH = 8;
  localparam int DW = 16;
  localparam int AW = 12;
  localparam int MON_W = 5;

  // Register byte offsets on the APB port
  localparam logic [11:0] OFF_SPAN = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_REF = 12'h008;
  localparam logic [11:0] OFF_MON = 12'h00c;
  localparam logic [11:0] OFF_CODE0 = 12'h010;
  localparam logic [11:0] OFF_CODE_STEP = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h030;

  // Field positions
  localparam int REF_EN_BIT = 0;
  localparam int STAT_REF_BIT = 8;
  localparam int STAT_REJ_BIT = 9;

  typedef enum logic [1:0] {
    DCM_MODE_NORMAL = 2'b00,
    DCM_MODE_PD_1K = 2'b01,
    DCM_MODE_PD_7K7 = 2'b10,
    DCM_MODE_PD_32K = 2'b11
  } dcm_mode_t;

  typedef enum logic [1:0] {
    DCM_MON_VOLT = 2'b00,
    DCM_MON_CURR = 2'b01,
    DCM_MON_TEMP = 2'b10,
    DCM_MON_AUX = 2'b11
  } dcm_mon_kind_t;

  // Reset values and full-scale code
  localparam logic [1:0] MODE_RST = 2'b11;
  localparam logic SPAN_RST = 1'b0;
  localparam logic REF_RST = 1'b0;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] CODE_MAX = 16'hffff;

  // Monitor source codes
  localparam logic [4:0] MON_RST = 5'h00;
  localparam logic [4:0] MON_CURR_BASE = 5'h08;
  localparam logic [4:0] MON_AUX_BASE = 5'h10;
  localparam logic [4:0] MON_TEMP = 5'h19;
  localparam logic [4:0] MON_LAST = 5'h1a;

endpackage : dcm_pkg

// >>> design/dcm_chan.sv
module dcm_chan #(
  parameter int DW = dcm_pkg::DW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic span,
  input wire logic [DW-1:0] code,
  output logic [DW-1:0] out_code,
  output logic gain2,
  output logic amp_on,
  output logic pd_1k,
  output logic pd_7k7,
  output logic pd_32k
);

  dcm_pkg::dcm_mode_t mode_e;
  wire normal;

  assign mode_e = dcm_pkg::dcm_mode_t'(mode);
  assign normal = mode_e == dcm_pkg::DCM_MODE_NORMAL;

  // Code to the converter freezes while powered down; the stored code still changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_code <= dcm_pkg::CODE_RST;
      gain2 <= dcm_pkg::SPAN_RST;
      amp_on <= 1'b0;
      pd_1k <= 1'b0;
      pd_7k7 <= 1'b0;
      pd_32k <= 1'b1;
    end else begin
      out_code <= normal ? code : out_code;
      gain2 <= span;
      amp_on <= normal;
      pd_1k <= mode_e == dcm_pkg::DCM_MODE_PD_1K;
      pd_7k7 <= mode_e == dcm_pkg::DCM_MODE_PD_7K7;
      pd_32k <= mode_e == dcm_pkg::DCM_MODE_PD_32K;
    end
  end

endmodule : dcm_chan

// >>> design/dcm_ctrl.sv
// Notes on behaviour
// - Span bit clear gives gain 1 (reset default), set gives gain 2.
// - Channel code is unsigned straight binary, 0 to 65535.
// - Mode 00 normal, 01 1k pulldown, 10 7.7k pulldown, 11 32k amp off.
// - Every channel mode resets to 3: amplifier off, 32k load.
// - Powered-down channels still accept register access but output code freezes.
// - Reference select resets to external; writing 1 enables internal reference.
// - Monitor select routes one of 27 voltage, current, temperature or auxiliary sources.
// - Invalid monitor select write is discarded, previous selection kept.
// - Monitor code 0x19 routes the die temperature sensor to the monitor.
//
// The address map and the APB interface to the registers were chosen for this implementation.
module dcm_ctrl #(
  parameter int NCH = dcm_pkg::NCH,
  parameter int DW = dcm_pkg::DW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NCH*DW-1:0] channel_output,
  output logic [NCH-1:0] chan_gain2,
  output logic [NCH-1:0] chan_amp_on,
  output logic [NCH-1:0] chan_pd_1k,
  output logic [NCH-1:0] chan_pd_7k7,
  output logic [NCH-1:0] chan_pd_32k,
  output logic ref_internal_en,
  output logic [4:0] monitor_source_pick,
  output logic [1:0] monitor_kind,
  output logic [2:0] monitor_channel
);

  logic [NCH-1:0] span_q;
  logic [2*NCH-1:0] mode_q;
  logic ref_q;
  logic [4:0] mon_q;
  logic rej_q;
  logic [DW-1:0] code_q [NCH];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [4:0] pick_q;
  logic [1:0] kind_q;
  logic [2:0] chsel_q;
  logic first_q;

  logic [NCH-1:0] hit_code;
  logic [NCH-1:0] chan_active;
  logic [31:0] code_rd [NCH+1];

  wire setup_ph;
  wire wr_fire;
  wire hit_span;
  wire hit_mode;
  wire hit_ref;
  wire hit_mon;
  wire hit_stat;
  wire hit_any;
  wire [4:0] mon_wdata;
  wire mon_valid;
  wire mon_wr;
  wire [31:0] stat_word;
  wire [31:0] rd_word;
  dcm_pkg::dcm_mon_kind_t kind_d;
  wire [2:0] chsel_d;

  // Zero-wait slave: read data is captured in the setup cycle
  assign setup_ph = psel & ~penable;
  assign wr_fire = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  assign hit_span = paddr == dcm_pkg::OFF_SPAN;
  assign hit_mode = paddr == dcm_pkg::OFF_MODE;
  assign hit_ref = paddr == dcm_pkg::OFF_REF;
  assign hit_mon = paddr == dcm_pkg::OFF_MON;
  assign hit_stat = paddr == dcm_pkg::OFF_STAT;
  assign hit_any = hit_span | hit_mode | hit_ref | hit_mon | hit_stat | (|hit_code);

  // Only the low five bits form the code; higher bits are ignored
  assign mon_wdata = pwdata[4:0];
  assign mon_valid = mon_wdata <= dcm_pkg::MON_LAST;
  assign mon_wr = wr_fire & hit_mon;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [11:0] OFF = dcm_pkg::OFF_CODE0 + 12'(gi) * dcm_pkg::OFF_CODE_STEP;
      assign hit_code[gi] = paddr == OFF;
      assign chan_active[gi] = mode_q[2*gi +: 2] == dcm_pkg::DCM_MODE_NORMAL;
      assign code_rd[gi+1] = code_rd[gi] |
        (hit_code[gi] ? {{(32-DW){1'b0}}, code_q[gi]} : 32'h0000_0000);

      // Code writes are taken whatever the channel mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          code_q[gi] <= dcm_pkg::CODE_RST;
        end else if (wr_fire && hit_code[gi]) begin
          code_q[gi] <= pwdata[DW-1:0];
        end
      end

      dcm_chan #(
        .DW(DW)
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_q[2*gi +: 2]),
        .span(span_q[gi]),
        .code(code_q[gi]),
        .out_code(channel_output[gi*DW +: DW]),
        .gain2(chan_gain2[gi]),
        .amp_on(chan_amp_on[gi]),
        .pd_1k(chan_pd_1k[gi]),
        .pd_7k7(chan_pd_7k7[gi]),
        .pd_32k(chan_pd_32k[gi])
      );

      property p_code_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit_code[gi]) |=> code_q[gi] == $past(pwdata[DW-1:0]);
      endproperty
      AST_CODE_WR: assert property (p_code_wr)
        else $error("Channel code write was not stored");

      property p_out_follow;
        @(posedge pclk) disable iff (!presetn)
        chan_active[gi] |=> channel_output[gi*DW +: DW] == $past(code_q[gi]);
      endproperty
      AST_OUT_FOLLOW: assert property (p_out_follow)
        else $error("Normal channel output does not follow its code");

      property p_pd_hold;
        @(posedge pclk) disable iff (!presetn)
        !chan_active[gi] |=> $stable(channel_output[gi*DW +: DW]);
      endproperty
      AST_PD_HOLD: assert property (p_pd_hold)
        else $error("Powered-down channel output code changed");

      property p_mode_pins;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (chan_amp_on[gi] == $past(chan_active[gi])) &&
          (chan_pd_32k[gi] == ($past(mode_q[2*gi +: 2]) == dcm_pkg::DCM_MODE_PD_32K)) &&
          (chan_pd_1k[gi] == ($past(mode_q[2*gi +: 2]) == dcm_pkg::DCM_MODE_PD_1K));
      endproperty
      AST_MODE_PINS: assert property (p_mode_pins)
        else $error("Channel load controls disagree with its mode");
    end
  endgenerate

  assign code_rd[0] = 32'h0000_0000;

  assign stat_word = {22'h00_0000, rej_q, ref_q, {(8-NCH){1'b0}}, chan_active};

  assign rd_word =
    hit_span ? {{(32-NCH){1'b0}}, span_q} :
    hit_mode ? {{(32-2*NCH){1'b0}}, mode_q} :
    hit_ref ? {31'h0000_0000, ref_q} :
    hit_mon ? {27'h000_0000, mon_q} :
    hit_stat ? stat_word :
    code_rd[NCH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= (!pwrite && hit_any) ? rd_word : 32'h0000_0000;
      pslverr_q <= ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_q <= {NCH{dcm_pkg::SPAN_RST}};
    end else if (wr_fire && hit_span) begin
      span_q <= pwdata[NCH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= {NCH{dcm_pkg::MODE_RST}};
    end else if (wr_fire && hit_mode) begin
      mode_q <= pwdata[2*NCH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= dcm_pkg::REF_RST;
    end else if (wr_fire && hit_ref) begin
      ref_q <= pwdata[dcm_pkg::REF_EN_BIT];
    end
  end

  // A rejected write leaves the selection alone but is reported in status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_q <= dcm_pkg::MON_RST;
      rej_q <= 1'b0;
    end else if (mon_wr) begin
      mon_q <= mon_valid ? mon_wdata : mon_q;
      rej_q <= ~mon_valid;
    end
  end

  // Monitor routing: 8 voltages, 8 currents, temperature and ten auxiliary points
  assign kind_d =
    (mon_q == dcm_pkg::MON_TEMP) ? dcm_pkg::DCM_MON_TEMP :
    (mon_q < dcm_pkg::MON_CURR_BASE) ? dcm_pkg::DCM_MON_VOLT :
    (mon_q < dcm_pkg::MON_AUX_BASE) ? dcm_pkg::DCM_MON_CURR :
    dcm_pkg::DCM_MON_AUX;
  assign chsel_d = (mon_q < dcm_pkg::MON_AUX_BASE) ? mon_q[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_q <= dcm_pkg::MON_RST;
      kind_q <= dcm_pkg::DCM_MON_VOLT;
      chsel_q <= 3'h0;
    end else begin
      pick_q <= mon_q;
      kind_q <= kind_d;
      chsel_q <= chsel_d;
    end
  end

  assign monitor_source_pick = pick_q;
  assign monitor_kind = kind_q;
  assign monitor_channel = chsel_q;
  assign ref_internal_en = ref_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  sequence s_mon_bad_wr;
    mon_wr && !mon_valid;
  endsequence

  sequence s_mon_good_wr;
    mon_wr && mon_valid;
  endsequence

  sequence s_temp_wr;
    mon_wr && (mon_wdata == 5'h19);
  endsequence

  sequence s_temp_routed;
    (mon_q == dcm_pkg::MON_TEMP) ##1 (monitor_kind == dcm_pkg::DCM_MON_TEMP);
  endsequence

  AST_RESET_VALUES: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_q |-> (mode_q == {NCH{2'b11}}) && (span_q == '0) && (chan_pd_32k == '1) &&
      !ref_internal_en)
    else $error("Reset values wrong at first edge");

  AST_GAIN_FOLLOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && hit_span) |=> ##1 chan_gain2 == $past(pwdata[NCH-1:0], 2))
    else $error("Gain controls do not follow span write");

  AST_REF_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && hit_ref) |=> ref_internal_en == $past(pwdata[0]))
    else $error("Reference select not taken from write");

  AST_MON_DISCARD: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_mon_bad_wr |=> $stable(mon_q) && rej_q)
    else $error("Invalid monitor write changed the selection");

  AST_MON_ACCEPT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_mon_good_wr |=> (mon_q == $past(mon_wdata)) ##1 (monitor_source_pick == $past(mon_wdata, 2)))
    else $error("Valid monitor write not routed");

  AST_MON_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    monitor_source_pick <= 5'h1a)
    else $error("Monitor selection outside the 27 sources");

  AST_TEMP_ROUTE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_temp_wr |=> s_temp_routed)
    else $error("Temperature code did not route the sensor");

  AST_UNMAPPED_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !hit_any) |=> pslverr && (prdata == 32'h0000_0000))
    else $error("Unmapped access not answered with an error");

endmodule : dcm_ctrl

// >>> dv/dcm_host.sv
module dcm_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
  end
  // Released address and data lines carry inverted values so a slave cannot lean on stale ones
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit hung);
    int n;
    hung = 1'b1;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        break;
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : dcm_host

// >>> dv/dac_channel_mode_monitor_ctrl_bench.sv
module dac_channel_mode_monitor_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [dcm_pkg::NCH*dcm_pkg::DW-1:0] chan_out;
  logic [7:0] gain2, amp_on, pd1, pd7, pd32;
  logic [4:0] pick;
  logic [1:0] kind;
  logic [2:0] mch;
  int fail_count = 0;
  int comparisons = 0;
  dcm_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dcm_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_output(chan_out), .chan_gain2(gain2),
    .chan_amp_on(amp_on), .chan_pd_1k(pd1), .chan_pd_7k7(pd7), .chan_pd_32k(pd32),
    .ref_internal_en(ref_en), .monitor_source_pick(pick), .monitor_kind(kind),
    .monitor_channel(mch));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    bit hung;
    host.xfer(w, a, d, rd, err, hung);
    if (hung) begin
      fail_count++;
      print_verdict();
    end
  endtask : acc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    acc(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    acc(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rd_chk
  // Channel and monitor outputs follow their registers one edge later
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic t_reset_values();
    #1;
    chk({24'h0, pd32}, 32'hff);
    chk({24'h0, amp_on}, 32'h0);
    chk({24'h0, gain2}, 32'h0);
    chk({31'h0, ref_en}, 32'h0);
    rd_chk(dcm_pkg::OFF_MODE, 32'hffff);
    rd_chk(dcm_pkg::OFF_SPAN, 32'h0);
  endtask : t_reset_values
  task automatic t_modes_codes();
    wr(dcm_pkg::OFF_MODE, 32'he4e4);
    wr(dcm_pkg::OFF_CODE0, 32'hffff);
    wr(dcm_pkg::OFF_CODE0 + dcm_pkg::OFF_CODE_STEP, 32'h1234);
    settle();
    chk({24'h0, amp_on}, 32'h11);
    chk({24'h0, pd1}, 32'h22);
    chk({24'h0, pd7}, 32'h44);
    chk({24'h0, pd32}, 32'h88);
    chk({16'h0, chan_out[15:0]}, 32'hffff);
    chk({16'h0, chan_out[31:16]}, 32'h0);
    rd_chk(dcm_pkg::OFF_CODE0 + dcm_pkg::OFF_CODE_STEP, 32'h1234);
    rd_chk(dcm_pkg::OFF_MODE, 32'he4e4);
    // Leaving power-down must pick up the code written while the output was frozen
    wr(dcm_pkg::OFF_MODE, 32'he4e0);
    settle();
    chk({16'h0, chan_out[31:16]}, 32'h1234);
    chk({24'h0, amp_on}, 32'h13);
  endtask : t_modes_codes
  task automatic t_span_ref();
    wr(dcm_pkg::OFF_SPAN, 32'ha5);
    wr(dcm_pkg::OFF_REF, 32'h1);
    settle();
    chk({24'h0, gain2}, 32'ha5);
    chk({31'h0, ref_en}, 32'h1);
  endtask : t_span_ref
  task automatic t_monitor();
    logic [4:0] prev;
    logic [1:0] k;
    prev = 5'h00;
    for (int c = 0; c < 32; c++) begin
      wr(dcm_pkg::OFF_MON, 32'(c));
      if (c <= 32'h1a) begin
        prev = 5'(c);
      end
      k = (prev < 5'h08) ? 2'b00 : (prev < 5'h10) ? 2'b01 : (prev == 5'h19) ? 2'b10 : 2'b11;
      settle();
      chk({27'h0, pick}, {27'h0, prev});
      chk({30'h0, kind}, {30'h0, k});
      chk({29'h0, mch}, (prev < 5'h10) ? {29'h0, prev[2:0]} : 32'h0);
    end
    rd_chk(dcm_pkg::OFF_MON, 32'h1a);
    // Status: last write rejected, internal reference, channels 0, 1 and 4 active
    rd_chk(dcm_pkg::OFF_STAT, 32'h313);
  endtask : t_monitor
  task automatic t_unmapped();
    logic [31:0] rd;
    logic err;
    acc(1'b0, 12'h0fc, 32'h0, rd, err);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_unmapped
  // A reset in mid-run must restore every default, not only the first one
  task automatic t_reset_again();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    chk({27'h0, pick}, 32'h0);
    rd_chk(dcm_pkg::OFF_CODE0, 32'h0);
  endtask : t_reset_again
  initial begin
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_modes_codes();
    t_span_ref();
    t_monitor();
    t_unmapped();
    t_reset_again();
    print_verdict();
  end
endmodule : dac_channel_mode_monitor_ctrl_bench
